// ==== cca_defs.vh ====
// Purpose: constants for the counter array capture/compare block
// Assumes: one 8-bit special-function register port, byte-wide accesses
// Notes:   register indices other than array control are local choices
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH

// ****************************************************************
// register map
// ****************************************************************
`define CCA_ADDR_CTRL      8'hD8
`define CCA_ADDR_CNT_LO    8'hE0
`define CCA_ADDR_CNT_HI    8'hE1
`define CCA_ADDR_IRQEN     8'hE2
`define CCA_ADDR_MODE0     8'hE8
`define CCA_ADDR_CMPLO0    8'hF0
`define CCA_ADDR_CMPHI0    8'hF8

// ****************************************************************
// field positions
// ****************************************************************
`define CCA_CTRL_OVF       7
`define CCA_CTRL_RUN       6
`define CCA_MODE_WIDE      7
`define CCA_MODE_CMPEN     6
`define CCA_MODE_CAPR      5
`define CCA_MODE_CAPF      4
`define CCA_MODE_MATCH     3
`define CCA_MODE_TOG       2
`define CCA_MODE_PULSE     1
`define CCA_MODE_IRQEN     0
`define CCA_IRQEN_GLOBAL   0
`define CCA_IRQEN_ARRAY    1

// ****************************************************************
// reset values
// ****************************************************************
`define CCA_RST_BYTE       8'h00

`endif

// ==== cca_counter_array.v ====
// Purpose: shared 16-bit counter with six capture/compare modules
// Assumes: counter ticks on every enabled clock without a counter byte write, byte register port
// Notes:   module flags sit in control bits 5..0; writes of 0 clear them

`include "cca_defs.vh"

// How it works
// - each module has its own mode register choosing its operating mode
// - capture on rise, fall, or both edges per the two capture bits
// - compare and match set: toggle picks software timer or high-speed output
// - compare plus pulse mode: wide bit picks 8-bit or 16-bit pwm
// - module interrupt needs module, global and array enables; overflow needs only global and array
// - frequency mode: low byte match toggles pin, adds high byte to low
// - square wave period is twice high byte counts; zero means 256
// - frequency mode: compare, toggle, pulse set, captures clear, match ignored
// - 8-bit pwm: pin goes high when counter low byte equals compare low
// - 8-bit pwm: pin goes low when counter low byte overflows, unless high byte is zero
// - 8-bit pwm: low byte reloads from high byte on low-byte rollover
// - 8-bit pwm: compare and pulse set, toggle and wide clear, no capture
// - writing compare low clears compare enable; writing high sets it
// - 8-bit pwm high time is (256 minus high byte) over 256
// - compare enable clear holds 8-bit pwm output low
// - overflow flag at control bit 7 set on 16-bit counter overflow
// - overflow flag is never cleared by hardware
// - event flag set on 16-bit timer or 16-bit pwm match or on capture, cleared only by software
// - counter is high and low byte; low byte feeds 8-bit compares
module cca_counter_array #(
	parameter NMOD = 6
) (
	input  wire            clk,
	input  wire            rstn,
	input  wire [7:0]      regAddr,
	input  wire [7:0]      regWdata,
	input  wire            regWr,
	input  wire            regRd,
	output reg  [7:0]      regRdata,
	input  wire [NMOD-1:0] pinIn,
	output reg  [NMOD-1:0] pinOut,
	output reg  [NMOD-1:0] pinOe,
	output reg             irqReq
);

	// ****************************************************************
	// shared counter and control
	// ****************************************************************
	reg  [15:0]     cnt_q;
	reg             ovf_q;
	reg             run_q;
	reg  [1:0]      irqEn_q;
	reg  [NMOD-1:0] evtFlag_q;
	reg  [NMOD-1:0] pinPrev_q;
	reg  [7:0]      mode_q  [0:NMOD-1];
	reg  [7:0]      cmpLo_q [0:NMOD-1];
	reg  [7:0]      cmpHi_q [0:NMOD-1];
	wire [NMOD-1:0] evtSet;
	wire [7:0]      modRd   [0:NMOD-1];
	wire            ctrlWr;
	wire            cntLoWr;
	wire            cntHiWr;
	wire            irqEnWr;
	wire [15:0]     cntInc;
	wire            lowWrap;
	wire            cntWrap;

	assign ctrlWr  = regWr && (regAddr == `CCA_ADDR_CTRL);
	assign cntLoWr = regWr && (regAddr == `CCA_ADDR_CNT_LO);
	assign cntHiWr = regWr && (regAddr == `CCA_ADDR_CNT_HI);
	assign irqEnWr = regWr && (regAddr == `CCA_ADDR_IRQEN);
	assign cntInc  = cnt_q + 16'h0001;
	assign lowWrap = run_q && (cnt_q[7:0] == 8'hFF);
	assign cntWrap = run_q && (cnt_q == 16'hFFFF);

	// a byte write overrides the increment in the same cycle
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 16'h0000;
		end else if (cntLoWr) begin
			cnt_q[7:0] <= regWdata;
		end else if (cntHiWr) begin
			cnt_q[15:8] <= regWdata;
		end else if (run_q) begin
			cnt_q <= cntInc;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_q <= 1'b0;
		end else if (ctrlWr) begin
			run_q <= regWdata[`CCA_CTRL_RUN];
		end
	end

	// set beats a same-cycle software clear
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ovf_q <= 1'b0;
		end else if (cntWrap) begin
			ovf_q <= 1'b1;
		end else if (ctrlWr) begin
			ovf_q <= regWdata[`CCA_CTRL_OVF];
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqEn_q <= 2'b00;
		end else if (irqEnWr) begin
			irqEn_q <= regWdata[1:0];
		end
	end

	// ****************************************************************
	// per-module capture/compare
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < NMOD; g = g + 1) begin : gMod
			wire [7:0] m;
			wire       bWide;
			wire       bCmpEn;
			wire       bCapR;
			wire       bCapF;
			wire       bMatch;
			wire       bTog;
			wire       bPulse;
			wire       anyCap;
			wire       capMode;
			wire       freqMode;
			wire       pwm8Mode;
			wire       pwm16Mode;
			wire       tmrMode;
			wire       risePin;
			wire       fallPin;
			wire       capHit;
			wire       loMatch;
			wire       pwmHit;
			wire       fullMatch;
			wire       wMode;
			wire       wLo;
			wire       wHi;

			// ********************************************************
			// mode decode
			// ********************************************************
			assign m      = mode_q[g];
			assign bWide  = m[`CCA_MODE_WIDE];
			assign bCmpEn = m[`CCA_MODE_CMPEN];
			assign bCapR  = m[`CCA_MODE_CAPR];
			assign bCapF  = m[`CCA_MODE_CAPF];
			assign bMatch = m[`CCA_MODE_MATCH];
			assign bTog   = m[`CCA_MODE_TOG];
			assign bPulse = m[`CCA_MODE_PULSE];
			assign anyCap = bCapR || bCapF;
			assign capMode   = anyCap && !bMatch && !bTog && !bPulse;
			assign tmrMode   = bCmpEn && bMatch && !bPulse && !anyCap;
			assign freqMode  = bCmpEn && bTog && bPulse && !anyCap;
			// enable left out so that a cleared enable can hold the pin low
			assign pwm8Mode  = bPulse && !bTog && !bWide && !anyCap;
			assign pwm16Mode = bCmpEn && bPulse && !bTog && bWide && !anyCap;

			// ********************************************************
			// register strobes and pin edges
			// ********************************************************
			assign wMode   = regWr && (regAddr == `CCA_ADDR_MODE0 + g);
			assign wLo     = regWr && (regAddr == `CCA_ADDR_CMPLO0 + g);
			assign wHi     = regWr && (regAddr == `CCA_ADDR_CMPHI0 + g);
			assign risePin = pinIn[g] && !pinPrev_q[g];
			assign fallPin = !pinIn[g] && pinPrev_q[g];
			assign capHit  = capMode && ((bCapR && risePin) || (bCapF && fallPin));

			// ********************************************************
			// compare matches
			// ********************************************************
			assign loMatch   = run_q && (cnt_q[7:0] == cmpLo_q[g]);
			// one count ahead, so the pin is high while the low byte equals it
			assign pwmHit    = run_q && (cntInc[7:0] == cmpLo_q[g]);
			assign fullMatch = run_q && (cnt_q == {cmpHi_q[g], cmpLo_q[g]});
			assign evtSet[g] = capHit
				|| ((tmrMode || pwm16Mode) && fullMatch);

			assign modRd[g] = (regAddr == `CCA_ADDR_MODE0 + g) ? mode_q[g]
				: (regAddr == `CCA_ADDR_CMPLO0 + g) ? cmpLo_q[g]
				: (regAddr == `CCA_ADDR_CMPHI0 + g) ? cmpHi_q[g]
				: 8'h00;

			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					pinPrev_q[g] <= 1'b0;
					pinOe[g]     <= 1'b0;
				end else begin
					pinPrev_q[g] <= pinIn[g];
					pinOe[g]     <= !capMode && (bTog || bPulse);
				end
			end

			// compare-byte writes override the enable bit
			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					mode_q[g] <= `CCA_RST_BYTE;
				end else if (wMode) begin
					mode_q[g] <= regWdata;
				end else if (wLo) begin
					mode_q[g][`CCA_MODE_CMPEN] <= 1'b0;
				end else if (wHi) begin
					mode_q[g][`CCA_MODE_CMPEN] <= 1'b1;
				end
			end

			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					cmpLo_q[g] <= `CCA_RST_BYTE;
				end else if (wLo) begin
					cmpLo_q[g] <= regWdata;
				end else if (capHit) begin
					cmpLo_q[g] <= cnt_q[7:0];
				end else if (freqMode && loMatch) begin
					cmpLo_q[g] <= cmpLo_q[g] + cmpHi_q[g];
				end else if (pwm8Mode && lowWrap) begin
					cmpLo_q[g] <= cmpHi_q[g];
				end
			end

			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					cmpHi_q[g] <= `CCA_RST_BYTE;
				end else if (wHi) begin
					cmpHi_q[g] <= regWdata;
				end else if (capHit) begin
					cmpHi_q[g] <= cnt_q[15:8];
				end
			end

			// 8-bit adds wrap, so a zero step gives a 256-count half period
			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					pinOut[g] <= 1'b0;
				end else if (freqMode && loMatch) begin
					pinOut[g] <= !pinOut[g];
				end else if (pwm8Mode && !bCmpEn) begin
					pinOut[g] <= 1'b0;
				end else if (pwm8Mode && lowWrap) begin
					pinOut[g] <= (cmpHi_q[g] == 8'h00);
				end else if (pwm8Mode && pwmHit) begin
					pinOut[g] <= 1'b1;
				end else if (pwm16Mode && cntWrap) begin
					pinOut[g] <= 1'b0;
				end else if (pwm16Mode && fullMatch) begin
					pinOut[g] <= 1'b1;
				end else if (tmrMode && bTog && fullMatch) begin
					pinOut[g] <= !pinOut[g];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// event flags, interrupt and readback
	// ****************************************************************
	integer        i;
	reg [NMOD-1:0] modIrq;
	reg [7:0]      modRdAll;

	always @* begin
		modIrq   = {NMOD{1'b0}};
		modRdAll = 8'h00;
		for (i = 0; i < NMOD; i = i + 1) begin
			modIrq[i] = evtFlag_q[i] && mode_q[i][`CCA_MODE_IRQEN];
			modRdAll  = modRdAll | modRd[i];
		end
	end

	// set wins over clear in the same cycle
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			evtFlag_q <= {NMOD{1'b0}};
		end else if (ctrlWr) begin
			evtFlag_q <= (regWdata[NMOD-1:0] & evtFlag_q) | evtSet;
		end else begin
			evtFlag_q <= evtFlag_q | evtSet;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqReq <= 1'b0;
		end else begin
			irqReq <= irqEn_q[`CCA_IRQEN_GLOBAL] && irqEn_q[`CCA_IRQEN_ARRAY]
				&& (ovf_q || (|modIrq));
		end
	end

	// unmapped addresses fall through as zero
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			regRdata <= 8'h00;
		end else if (!regRd) begin
			regRdata <= 8'h00;
		end else if (regAddr == `CCA_ADDR_CTRL) begin
			regRdata <= {ovf_q, run_q, evtFlag_q};
		end else if (regAddr == `CCA_ADDR_CNT_LO) begin
			regRdata <= cnt_q[7:0];
		end else if (regAddr == `CCA_ADDR_CNT_HI) begin
			regRdata <= cnt_q[15:8];
		end else if (regAddr == `CCA_ADDR_IRQEN) begin
			regRdata <= {6'h00, irqEn_q};
		end else begin
			regRdata <= modRdAll;
		end
	end

endmodule // cca_counter_array

// ==== cca_pin_model.sv ====
// Purpose: external circuitry on the module pins
// Assumes: a driving module owns the wire, otherwise the bench level shows
// Notes:   no pull resistors on these pins
module cca_pin_model (
	input  wire  [5:0] pinOut,
	input  wire  [5:0] pinOe,
	input  wire  [5:0] extLvl,
	output logic [5:0] pinIn
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLvl);
endmodule // cca_pin_model

// ==== cca_counter_array_props.sv ====
// Purpose: port checks for the counter array
// Assumes: shadows follow module 0 and the counter low byte
// Notes:   shadows lag nothing; outputs are registered, hence the stable guards
module cca_counter_array_props #(parameter NMOD = 6) (
	input wire            clk,
	input wire            rstn,
	input wire [7:0]      regAddr,
	input wire [7:0]      regWdata,
	input wire            regWr,
	input wire            regRd,
	input wire [7:0]      regRdata,
	input wire [NMOD-1:0] pinIn,
	input wire [NMOD-1:0] pinOut,
	input wire [NMOD-1:0] pinOe,
	input wire            irqReq
);
	logic [1:0] irqEnQ;
	logic [7:0] modeQ;
	logic [7:0] cntQ;
	logic       runQ;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqEnQ <= 2'h0;
			modeQ  <= 8'h00;
			cntQ   <= 8'h00;
			runQ   <= 1'b0;
		end else begin
			if (regWr && regAddr == 8'hE2) irqEnQ <= regWdata[1:0];
			if (regWr && regAddr == 8'hD8) runQ <= regWdata[6];
			if (regWr && regAddr == 8'hE8) modeQ <= regWdata;
			else if (regWr && regAddr == 8'hF0) modeQ[6] <= 1'b0;
			else if (regWr && regAddr == 8'hF8) modeQ[6] <= 1'b1;
			if (regWr && regAddr == 8'hE0) cntQ <= regWdata;
			else if (runQ) cntQ <= cntQ + 8'h01;
		end
	end
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property ($past(regRd && regAddr == 8'h00) |-> regRdata == 8'h00)
		else $error("unmapped read not zero");
	a_cnt_read: assert property ($past(regRd && regAddr == 8'hE0) |-> regRdata == $past(cntQ))
		else $error("counter low byte wrong");
	a_ctrl_run: assert property ($past(regRd && regAddr == 8'hD8) |-> regRdata[6] == $past(runQ))
		else $error("run bit wrong");
	a_irq_gated: assert property (!(&irqEnQ) && !(&$past(irqEnQ)) |-> !irqReq)
		else $error("interrupt without enables");
	a_oe_mode: assert property ($stable(modeQ) |->
		pinOe[0] == ((modeQ[2] | modeQ[1]) && !(modeQ[5] | modeQ[4])))
		else $error("output enable wrong for mode");
	a_pwm_off_low: assert property ($stable(modeQ) && modeQ[7:4] == 4'h0 && modeQ[2:1] == 2'h1
		|-> !pinOut[0])
		else $error("pwm output high with compare off");
	a_capture_hold: assert property ($stable(modeQ) && (modeQ[5] | modeQ[4]) |-> $stable(pinOut[0]))
		else $error("pin moved in capture mode");
endmodule // cca_counter_array_props
bind cca_counter_array cca_counter_array_props #(.NMOD(NMOD)) u_props (.clk(clk), .rstn(rstn),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irqReq(irqReq));

// ==== cca_counter_array_tb_top.sv ====
// Purpose: self-checking bench for the counter array
// Assumes: module 0 carries the 8-bit pwm, frequency and capture pin scenarios
// Notes:   8-bit pwm and frequency results are measured as pin spans in clocks
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
	$display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module cca_counter_array_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, rstn = 0, regWr = 0, regRd = 0, irqReq;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
	logic [5:0] pinIn, pinOut, pinOe, extLvl = 6'h00;
	logic [7:0] capMode [3] = '{8'h21, 8'h11, 8'h31};
	int         errors = 0, checked = 0, seed = 22, n, m, hF, hP;
	always #25 clk = ~clk;
	cca_counter_array u_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .irqReq(irqReq));
	cca_pin_model u_pins (.pinOut(pinOut), .pinOe(pinOe), .extLvl(extLvl), .pinIn(pinIn));
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		regAddr = a;
		regWdata = v;
		regWr = 1;
		@(negedge clk);
		regWr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] exp);
		@(negedge clk);
		regAddr = a;
		regRd = 1;
		@(negedge clk);
		regRd = 0;
		`CHK(regRdata & msk, exp);
	endtask
	// counts clocks while pin 0 holds lvl, bounded
	task automatic span(input logic lvl, output int k);
		k = 0;
		while (pinOut[0] === lvl && k < 1000) begin
			@(negedge clk);
			k++;
		end
	endtask
	task automatic summarize;
		if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rstn = 1;
		rd(8'hD8, 8'hFF, 8'h00);
		rd(8'h00, 8'hFF, 8'h00);
		for (m = 0; m < 6; m++) begin
			hP = $random(seed);
			wr(8'(8'hE8 + m), 8'h42);
			wr(8'(8'hF0 + m), hP[7:0]);
			rd(8'(8'hE8 + m), 8'hFF, 8'h02);
			wr(8'(8'hF8 + m), hP[15:8]);
			rd(8'(8'hE8 + m), 8'hFF, 8'h42);
			rd(8'(8'hF8 + m), 8'hFF, hP[15:8]);
		end
		wr(8'hE1, 8'hFF);
		wr(8'hE0, 8'hFE);
		wr(8'hD8, 8'h40);
		repeat (10) @(negedge clk);
		rd(8'hD8, 8'hC0, 8'hC0);
		wr(8'hD8, 8'hBF);
		rd(8'hE0, 8'hFF, 8'h0C);
		repeat (5) @(negedge clk);
		rd(8'hD8, 8'hC0, 8'h80);
		wr(8'hD8, 8'h3F);
		rd(8'hD8, 8'hC0, 8'h00);
		hF = 2 + ($random(seed) & 15);
		wr(8'hF8, hF[7:0]);
		wr(8'hE8, 8'h46);
		wr(8'hD8, 8'h40);
		span(pinOut[0], n);
		span(pinOut[0], n);
		`CHK(n, hF);
		hP = 1 + ($random(seed) & 8'hFE);
		wr(8'hF8, hP[7:0]);
		wr(8'hE8, 8'h42);
		// first high may use the stale low byte, so skip one period
		span(1'b1, n);
		span(1'b0, n);
		span(1'b1, n);
		span(1'b0, n);
		span(1'b1, n);
		`CHK(n, 256 - hP);
		wr(8'hF0, 8'h00);
		repeat (2) @(negedge clk);
		for (m = 0; m < 300; m++) begin
			@(negedge clk);
			`CHK(pinOut[0], 1'b0);
		end
		wr(8'hD8, 8'h00);
		wr(8'hE1, 8'hFF);
		wr(8'hE0, 8'hF8);
		for (m = 1; m < 3; m++) begin
			wr(8'(8'hF0 + m), 8'h08);
			wr(8'(8'hF8 + m), 8'h00);
		end
		wr(8'hE9, 8'h4C);
		wr(8'hEA, 8'hC2);
		hF = pinOut[1];
		wr(8'hD8, 8'h40);
		repeat (12) @(negedge clk);
		`CHK(pinOut[2], 1'b0);
		`CHK(pinOut[1], hF[0]);
		repeat (10) @(negedge clk);
		`CHK(pinOut[2], 1'b1);
		`CHK(pinOut[1], ~hF[0]);
		rd(8'hD8, 8'h06, 8'h06);
		wr(8'hE2, 8'h03);
		for (m = 0; m < 3; m++) begin
			wr(8'hE8, capMode[m]);
			wr(8'hD8, 8'h00);
			wr(8'hE0, 8'h01);
			extLvl[0] = 1;
			repeat (3) @(negedge clk);
			wr(8'hE0, 8'h02);
			extLvl[0] = 0;
			repeat (3) @(negedge clk);
			rd(8'hF0, 8'hFF, capMode[m][4] ? 8'h02 : 8'h01);
			rd(8'hD8, 8'h01, 8'h01);
			`CHK(irqReq, 1'b1);
			wr(8'hE2, 8'h02);
			@(negedge clk);
			`CHK(irqReq, 1'b0);
			wr(8'hE2, 8'h03);
		end
		summarize;
	end
	initial begin
		#2000000;
		errors++;
		summarize;
	end
endmodule // cca_counter_array_tb_top
